// file: include/sto_monitor_cfg.svh
// Constants for the safe torque off input and monitor block
`ifndef STO_MONITOR_CFG_SVH
`define STO_MONITOR_CFG_SVH

`define CLK_FREQ_HZ        10000000
`define TEST_PULSE_MAX_US  1000
`define FILTER_MARGIN_CYC  2
`define FILTER_MIN_CYC     2
`define FILTER_CYCLES      ((`TEST_PULSE_MAX_US * (`CLK_FREQ_HZ / 1000000)) + `FILTER_MARGIN_CYC)
`define ALARM_CODE_TIMING  8'h3f
`define ALARM_CODE_NONE    8'h00

`endif

// file: include/sto_monitor_pkg.sv
// Types for the safe torque off input and monitor block
package sto_monitor_pkg;
    typedef logic [7:0] alarm_code_t;
endpackage : sto_monitor_pkg

// file: design/safe_torque_off_monitor.sv
// Safe torque off input filtering, base shut-off and monitor outputs
//
// How it works
// - Channel A open forces base shut-off; driving is allowed only with both channels closed.
// - Channel B open forces base shut-off regardless of channel A.
// - Monitor A conducts while channel A is shut off and is open while released.
// - Monitor B conducts while channel B is shut off and is open while released.
// - The common monitor is active only when both channels are shut off.
// - Opening a channel while the motor turns raises the timing alarm, code 63.
// - Forced stop deceleration is not offered in torque control mode.
`timescale 1ns/1ps
`include "sto_monitor_cfg.svh"

module safe_torque_off_monitor #(
    parameter int FILTER_CYCLES = `FILTER_CYCLES
) (
    input  wire logic                        MCLK,
    input  wire logic                        RSTN,
    input  wire logic                        SHUTOFF_IN_A,
    input  wire logic                        SHUTOFF_IN_B,
    input  wire logic                        MOTOR_ROTATING,
    input  wire logic                        TORQUE_MODE,
    input  wire logic                        FORCED_STOP_DECEL_IN,
    input  wire logic                        ALARM_CLEAR,
    output logic                             BASE_SHUTOFF,
    output logic                             SHUTOFF_MONITOR_A,
    output logic                             SHUTOFF_MONITOR_B,
    output logic                             SHUTOFF_MONITOR_COMMON,
    output logic                             FORCED_DECEL_REQ,
    output logic                             SHUTOFF_TIMING_ALARM,
    output sto_monitor_pkg::alarm_code_t     ALARM_CODE
);
    import sto_monitor_pkg::*;

    localparam int CW = $clog2(FILTER_CYCLES + 1);

    // ----------------------------------------
    // Parameter check
    // ----------------------------------------
    // Counter compare needs at least the minimum window
    if (FILTER_CYCLES < `FILTER_MIN_CYC) begin : g_bad_filter
        $error("FILTER_CYCLES too small");
    end

    // ----------------------------------------
    // State
    // ----------------------------------------

    typedef struct packed {
        logic [2:0]  sync_a;
        logic [2:0]  sync_b;
        logic [2:0]  sync_rot;
        logic [2:0]  sync_tq;
        logic [2:0]  sync_em;
        logic        clr_d;
        logic [CW-1:0] cnt_a;
        logic [CW-1:0] cnt_b;
        logic        off_a;
        logic        off_b;
        logic        base_off;
        logic        mon_a;
        logic        mon_b;
        logic        mon_c;
        logic        decel;
        logic        alarm;
        alarm_code_t code;
    } state_t;

    state_t st;
    state_t next_st;
    logic [1:0] rst_sync;
    logic       rst_n;

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // ----------------------------------------
    // Input helpers
    // ----------------------------------------
    // Stages 2 and 3 agree: the pin has settled
    function automatic logic agreed(input logic [2:0] s);
        return s[2] == s[1];
    endfunction : agreed

    // Settled opening, or the held decision while the pin moves
    function automatic logic open_sel(input logic [2:0] s, input logic held);
        logic sel;
        sel = held;
        if (agreed(s)) begin
            sel = ~s[2];
        end
        return sel;
    endfunction : open_sel

    // ----------------------------------------
    // Channel filter
    // ----------------------------------------
    // Filter step: opening must persist past the test pulse limit
    function automatic logic [CW:0] filt(input logic [CW-1:0] cnt, input logic open_now, input logic was_off);
        logic [CW-1:0] c;
        logic          off;
        c   = cnt;
        off = was_off;
        if (!open_now) begin
            c   = '0;
            off = 1'b0;
        end else if (c >= CW'(FILTER_CYCLES)) begin
            off = 1'b1;
        end else begin
            c = c + 1'b1;
        end
        return {off, c};
    endfunction : filt

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic [CW:0] ra;
        logic [CW:0] rb;
        logic        rot;
        logic        sel_a;
        logic        sel_b;
        next_st = st;
        // ----------------------------------------
        // Synchronisers
        // ----------------------------------------
        // Inputs high when closed
        next_st.sync_a   = {st.sync_a[1:0], SHUTOFF_IN_A};
        next_st.sync_b   = {st.sync_b[1:0], SHUTOFF_IN_B};
        next_st.sync_rot = {st.sync_rot[1:0], MOTOR_ROTATING};
        next_st.sync_tq  = {st.sync_tq[1:0], TORQUE_MODE};
        next_st.sync_em  = {st.sync_em[1:0], FORCED_STOP_DECEL_IN};

        // ----------------------------------------
        // Channel filters
        // ----------------------------------------
        sel_a = open_sel(st.sync_a, st.cnt_a != '0);
        sel_b = open_sel(st.sync_b, st.cnt_b != '0);
        ra = filt(st.cnt_a, sel_a, st.off_a);
        rb = filt(st.cnt_b, sel_b, st.off_b);
        next_st.off_a = ra[CW];
        next_st.cnt_a = ra[CW-1:0];
        next_st.off_b = rb[CW];
        next_st.cnt_b = rb[CW-1:0];

        // ----------------------------------------
        // Base shut-off and monitors
        // ----------------------------------------
        // Raw opening shuts the stage off at once; the filter only spares the monitors and the timing alarm
        next_st.base_off = sel_a | sel_b;
        next_st.mon_a = next_st.off_a;
        next_st.mon_b = next_st.off_b;
        next_st.mon_c = next_st.off_a & next_st.off_b;

        // ----------------------------------------
        // Forced stop request
        // ----------------------------------------
        // Forced stop 2 released low requests deceleration, not in torque mode
        next_st.decel = ~st.sync_em[2] & ~st.sync_em[1] & ~(st.sync_tq[2] & st.sync_tq[1]);

        // ----------------------------------------
        // Timing alarm
        // ----------------------------------------
        rot = agreed(st.sync_rot) ? st.sync_rot[2] : 1'b0;
        next_st.clr_d = ALARM_CLEAR;
        if (ALARM_CLEAR & ~st.clr_d) begin
            next_st.alarm = 1'b0;
            next_st.code  = `ALARM_CODE_NONE;
        end
        // Set wins over clear
        if (rot & ((next_st.off_a & ~st.off_a) | (next_st.off_b & ~st.off_b))) begin
            next_st.alarm = 1'b1;
            next_st.code  = `ALARM_CODE_TIMING;
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            st          <= '0;
            st.sync_a   <= 3'h0;
            st.sync_b   <= 3'h0;
            st.off_a    <= 1'b1;
            st.off_b    <= 1'b1;
            st.base_off <= 1'b1;
            st.mon_a    <= 1'b1;
            st.mon_b    <= 1'b1;
            st.mon_c    <= 1'b1;
            st.code     <= `ALARM_CODE_NONE;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign BASE_SHUTOFF           = st.base_off;
    assign SHUTOFF_MONITOR_A      = st.mon_a;
    assign SHUTOFF_MONITOR_B      = st.mon_b;
    assign SHUTOFF_MONITOR_COMMON = st.mon_c;
    assign FORCED_DECEL_REQ       = st.decel;
    assign SHUTOFF_TIMING_ALARM   = st.alarm;
    assign ALARM_CODE             = st.code;
endmodule : safe_torque_off_monitor

// file: tb/sto_safety_ctrl.sv
// Model of the outside safety controller that drives both shut-off inputs
`timescale 1ns/1ps
module sto_safety_ctrl #(parameter int TP = 6) (
    input  wire logic clk,
    input  wire logic open_a,
    input  wire logic open_b,
    input  wire logic tp,
    output logic      sto_a = 1'b1,
    output logic      sto_b = 1'b1
);
    int n = 0;
    always @(posedge clk) begin
        if (tp && n == 0) n <= TP;
        else if (n > 0) n <= n - 1;
        sto_a <= !(open_a || n > 0);
        sto_b <= !(open_b || n > 0);
    end
endmodule : sto_safety_ctrl

// file: tb/sto_monitor_asserts.sv
// Port assertions for the safe torque off monitor
`timescale 1ns/1ps
module sto_monitor_asserts (
    input wire logic MCLK, RSTN, SHUTOFF_IN_A, SHUTOFF_IN_B, TORQUE_MODE, BASE_SHUTOFF, FORCED_DECEL_REQ,
    input wire logic SHUTOFF_MONITOR_A, SHUTOFF_MONITOR_B, SHUTOFF_MONITOR_COMMON, SHUTOFF_TIMING_ALARM,
    input wire sto_monitor_pkg::alarm_code_t ALARM_CODE
);
    logic [3:0] up;
    always_ff @(posedge MCLK or negedge RSTN)
        if (!RSTN) up <= 4'h0;
        else if (!up[3]) up <= up + 4'h1;
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RSTN);
    sequence open_a_s; (up[3] && !SHUTOFF_IN_A)[*6]; endsequence
    sequence open_b_s; (up[3] && !SHUTOFF_IN_B)[*6]; endsequence
    a_base_chan_a: assert property (open_a_s |-> BASE_SHUTOFF) else $error("base on with A open");
    a_base_chan_b: assert property (open_b_s |-> BASE_SHUTOFF) else $error("base on with B open");
    a_base_release: assert property ((up[3] && SHUTOFF_IN_A && SHUTOFF_IN_B)[*6] |-> !BASE_SHUTOFF)
        else $error("base stuck off");
    a_mon_a_cause: assert property ($rose(SHUTOFF_MONITOR_A) |-> !$past(SHUTOFF_IN_A, 8))
        else $error("monitor A on short opening");
    a_mon_b_release: assert property ((up[3] && SHUTOFF_IN_B)[*7] |-> !SHUTOFF_MONITOR_B)
        else $error("monitor B stuck on");
    a_common_both: assert property ($rose(SHUTOFF_MONITOR_COMMON) |-> SHUTOFF_MONITOR_A && SHUTOFF_MONITOR_B)
        else $error("common on with one channel");
    a_decel_torque: assert property ((up[3] && TORQUE_MODE)[*6] |-> !FORCED_DECEL_REQ)
        else $error("decel in torque mode");
    a_alarm_code: assert property (ALARM_CODE == (SHUTOFF_TIMING_ALARM ? 8'h3f : 8'h00))
        else $error("alarm code wrong");
    a_alarm_cause: assert property ($rose(SHUTOFF_TIMING_ALARM) |-> SHUTOFF_MONITOR_A || SHUTOFF_MONITOR_B)
        else $error("alarm without opening");
endmodule : sto_monitor_asserts
bind safe_torque_off_monitor sto_monitor_asserts chk (.*);

// file: tb/tb_safe_torque_off_monitor.sv
// Self-checking bench for the safe torque off monitor
`timescale 1ns/1ps
module tb_safe_torque_off_monitor;
    logic MCLK = 0, RSTN = 0, rot = 0, trq = 0, em2 = 1, clr = 0, oa = 0, ob = 0, tp = 0;
    wire logic sa, sb, base, ma, mb, mc, dec, alm;
    sto_monitor_pkg::alarm_code_t code;
    wire logic [3:0] st = {base, ma, mb, mc};
    int errors = 0, samples_checked = 0;
    sto_safety_ctrl #(.TP(6)) ctrl (.clk(MCLK), .open_a(oa), .open_b(ob), .tp(tp), .sto_a(sa), .sto_b(sb));
    safe_torque_off_monitor #(.FILTER_CYCLES(8)) dut (.MCLK(MCLK), .RSTN(RSTN), .SHUTOFF_IN_A(sa),
        .SHUTOFF_IN_B(sb), .MOTOR_ROTATING(rot), .TORQUE_MODE(trq), .FORCED_STOP_DECEL_IN(em2),
        .ALARM_CLEAR(clr), .BASE_SHUTOFF(base), .SHUTOFF_MONITOR_A(ma), .SHUTOFF_MONITOR_B(mb),
        .SHUTOFF_MONITOR_COMMON(mc), .FORCED_DECEL_REQ(dec), .SHUTOFF_TIMING_ALARM(alm), .ALARM_CODE(code));
    initial forever #50 MCLK = ~MCLK;
    task automatic cyc(input int n); repeat (n) @(posedge MCLK); endtask : cyc
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic stop_test;
        if (errors == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : stop_test
    task automatic t_pulse;
        cyc(1); tp <= 1; cyc(1); tp <= 0; cyc(7); @(negedge MCLK);
        chk({4'h0, st}, 8'h08);
        repeat (20) begin
            @(negedge MCLK); chk({6'h0, ma, mb}, 8'h00);
        end
    endtask : t_pulse
    task automatic t_open(input logic a, input logic b, input logic r, input logic [7:0] e);
        cyc(1); oa <= a; ob <= b; rot <= r; cyc(25); @(negedge MCLK);
        chk({4'h0, st}, e);
        chk(code, r ? 8'h3f : 8'h00);
        cyc(1); oa <= 0; ob <= 0; rot <= 0; cyc(12); @(negedge MCLK);
        chk({3'h0, alm, st}, {3'h0, r, 4'h0});
    endtask : t_open
    task automatic t_clear_torque;
        cyc(1); clr <= 1; em2 <= 0; cyc(1); clr <= 0; cyc(8); @(negedge MCLK);
        chk({alm, dec, code[5:0]}, 8'h40);
        cyc(1); trq <= 1; cyc(8); @(negedge MCLK);
        chk({7'h0, dec}, 8'h00);
    endtask : t_clear_torque
    initial begin
        cyc(12); RSTN <= 1; cyc(12); @(negedge MCLK);
        chk({4'h0, st}, 8'h00);
        t_pulse;
        t_open(1'b1, 1'b0, 1'b0, 8'h0c);
        t_open(1'b0, 1'b1, 1'b0, 8'h0a);
        t_open(1'b1, 1'b1, 1'b0, 8'h0f);
        t_open(1'b1, 1'b1, 1'b1, 8'h0f);
        t_clear_torque;
        stop_test;
    end
    initial begin
        cyc(3000); errors++; stop_test;
    end
endmodule : tb_safe_torque_off_monitor
